// ### rtl/tgpcd_top.sv
// Command decoder with its AHB-Lite register slave.
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
module tgpcd_top (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	// AHB-Lite slave
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic                               hreadyout,
	output logic                               hresp,
	output logic [31:0]                        hrdata,
	// Front end configuration
	output tgpcd_pkg::tgpcd_fe_s [3:0]         feConfig,
	output logic [3:0]                         counterInit,
	// Telescope A control
	output tgpcd_pkg::tgpcd_tel_s              telescopeA,
	// Stimulus, timer and interrupt clear
	output logic [3:0]                         stimulusStrobeEnable,
	output logic [1:0]                         stimulusAmplitude,
	output logic [7:0]                         accumulationPeriod,
	output logic [3:0]                         singleCounterSelect,
	output logic                               irqClear
);

	// ****************************************
	// Bus address phase and data phase
	// ****************************************
	logic [7:0]                  wrAddr;
	logic                        wrPend;
	logic [7:0]                  stimulusPattern;
	logic [1:0]                  feIndex;
	tgpcd_pkg::tgpcd_state_e     state;
	tgpcd_pkg::tgpcd_state_e     next_state;

	wire        addrPhase = hsel & hready & htrans[1];
	wire        cmdValid  = wrPend & (wrAddr == tgpcd_pkg::REG_CMD);
	wire [7:0]  cmdByte   = hwdata[7:0];
	wire        idle      = (state == tgpcd_pkg::ST_OPCODE);
	wire        opByte    = cmdValid & idle;

	function automatic logic [31:0] readWord(input logic [7:0] a);
		logic [31:0] w;
		w = tgpcd_pkg::READ_ZERO;
		if (a == tgpcd_pkg::REG_STATUS) begin
			w = {~idle, 7'h00, stimulusPattern, 2'h0, stimulusAmplitude,
				stimulusStrobeEnable, 4'h0, telescopeA};
		end else if (a == tgpcd_pkg::REG_TIMER) begin
			w = {20'h00000, singleCounterSelect, accumulationPeriod};
		end else if (a[7:4] == tgpcd_pkg::REG_FE_BASE[7:4] &&
			a[1:0] == 2'h0 && a[3] == 1'b0) begin
			w = {6'h00, feConfig[a[2]]};
		end else if (a[7:4] == tgpcd_pkg::REG_FE_BASE[7:4] &&
			a[1:0] == 2'h0) begin
			w = {6'h00, feConfig[{1'b1, a[2]}]};
		end
		return w;
	endfunction

	wire [31:0] readData = readWord(haddr[7:0]);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPend    <= 1'b0;
			wrAddr    <= tgpcd_pkg::BYTE_RESET;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
			hrdata    <= tgpcd_pkg::READ_ZERO;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready) begin
				wrPend <= addrPhase & hwrite;
				wrAddr <= haddr[7:0];
				if (addrPhase & ~hwrite) begin
					hrdata <= readData;
				end
			end
		end
	end

	// ****************************************
	// Opcode decoding
	// ****************************************
	wire isFeCfg   = cmdByte[7:2] == tgpcd_pkg::OP_FE_CFG[7:2];
	wire isFilter  = cmdByte[7:4] == tgpcd_pkg::OP_FILTER[7:4];
	wire isCntInit = cmdByte[7:2] == tgpcd_pkg::OP_CNT_INIT[7:2];
	wire isSingle  = cmdByte[7:4] == tgpcd_pkg::OP_SINGLE[7:4];
	wire [1:0] sel = cmdByte[1:0];
	wire isStim    = cmdByte == tgpcd_pkg::OP_STIMULUS;
	wire isTimer   = cmdByte == tgpcd_pkg::OP_TIMER;
	wire isPowerA  = cmdByte == tgpcd_pkg::OP_POWER_A;
	wire isDriveA  = cmdByte == tgpcd_pkg::OP_DRIVE_A;
	wire isEnableA = cmdByte == tgpcd_pkg::OP_ENABLE_A;
	wire isDigital = cmdByte == tgpcd_pkg::OP_DIGITAL;
	wire isIrqClr  = cmdByte == tgpcd_pkg::OP_IRQ_CLEAR;

	function automatic logic [3:0] strobesOf(input logic [7:0] p);
		logic [3:0] s;
		s = tgpcd_pkg::STROBES_NONE;
		if (p == tgpcd_pkg::STIM_HALF) begin
			s = tgpcd_pkg::STROBES_HALF;
		end else if (p == tgpcd_pkg::STIM_ALL) begin
			s = tgpcd_pkg::STROBES_ALL;
		end
		return s;
	endfunction

	// ****************************************
	// Argument sequencing
	// ****************************************
	always_comb begin
		next_state = state;
		if (cmdValid) begin
			case (state)
				tgpcd_pkg::ST_OPCODE: begin
					if (isFeCfg) begin
						next_state = tgpcd_pkg::ST_FE_GAIN;
					end else if (isStim) begin
						next_state = tgpcd_pkg::ST_STIM_ARG;
					end else if (isTimer) begin
						next_state = tgpcd_pkg::ST_TIMER_ARG;
					end
				end
				tgpcd_pkg::ST_FE_GAIN: begin
					next_state = tgpcd_pkg::ST_FE_MAIN;
				end
				tgpcd_pkg::ST_FE_MAIN: begin
					next_state = tgpcd_pkg::ST_FE_COINC;
				end
				default: begin
					next_state = tgpcd_pkg::ST_OPCODE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state   <= tgpcd_pkg::ST_OPCODE;
			feIndex <= 2'h0;
		end else begin
			state <= next_state;
			if (opByte & isFeCfg) begin
				feIndex <= sel;
			end
		end
	end

	// ****************************************
	// Front end configuration and counters
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			feConfig    <= '0;
			counterInit <= 4'h0;
		end else begin
			counterInit <= 4'h0;
			if (cmdValid && state == tgpcd_pkg::ST_FE_GAIN) begin
				feConfig[feIndex].gainPrefix <= cmdByte[7:5];
				feConfig[feIndex].gain       <= cmdByte[4:0];
			end
			if (cmdValid && state == tgpcd_pkg::ST_FE_MAIN) begin
				feConfig[feIndex].mainLevelThreshold <= cmdByte;
			end
			if (cmdValid && state == tgpcd_pkg::ST_FE_COINC) begin
				feConfig[feIndex].coincidenceLevelThreshold <= cmdByte;
			end
			if (opByte & isFilter) begin
				feConfig[cmdByte[3:2]].filterMode <= sel;
			end
			if (opByte & isCntInit) begin
				counterInit[sel] <= 1'b1;
			end
		end
	end

	// ****************************************
	// Telescope control, stimulus and timer
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			telescopeA           <= '0;
			irqClear             <= 1'b0;
			stimulusPattern      <= tgpcd_pkg::BYTE_RESET;
			stimulusStrobeEnable <= tgpcd_pkg::STROBES_NONE;
			stimulusAmplitude    <= tgpcd_pkg::STIM_AMPL_OFF;
			accumulationPeriod   <= tgpcd_pkg::BYTE_RESET;
			singleCounterSelect  <= 4'h0;
		end else begin
			irqClear <= opByte & isIrqClr;
			if (opByte & isPowerA) begin
				telescopeA.power <= 1'b1;
			end
			if (opByte & isDriveA) begin
				telescopeA.drive <= 1'b1;
			end
			if (opByte & isEnableA) begin
				telescopeA.enable <= 1'b1;
			end
			if (opByte & isDigital) begin
				telescopeA.digital <= 1'b1;
			end
			if (opByte & isSingle) begin
				singleCounterSelect <= cmdByte[3:0];
			end
			if (cmdValid && state == tgpcd_pkg::ST_STIM_ARG) begin
				stimulusPattern      <= cmdByte;
				stimulusStrobeEnable <= strobesOf(cmdByte);
				stimulusAmplitude    <= tgpcd_pkg::STIM_AMPL_ONE;
			end
			if (cmdValid && state == tgpcd_pkg::ST_TIMER_ARG) begin
				accumulationPeriod <= cmdByte;
			end
		end
	end

endmodule

// ### rtl/tgpcd_pkg.sv
// Constants, types and command codes of the command decoder.
// How it works
// - Opcodes 0x90 to 0x93 configure front end n with three argument bytes.
// - First argument holds a three-bit prefix and a five-bit gain.
// - Opcode 0011nnmm sets filter mode mm for front end nn.
// - Opcodes 0xa8 to 0xab initialise the event counter of front end n.
// - Opcode 0xe0 takes a stimulus byte; 0x08 drives strobes 0,2, 0x0a all.
// - Opcode 0x82 switches on power to telescope A front ends.
// - Opcode 0x86 drives outputs towards telescope A front ends.
// - Opcode 0x8a puts telescope A front ends into acquisition mode.
// - Opcode 0x8c sets the front ends to digital mode.
// - Opcode 0x70 clears the interrupt register.
package tgpcd_pkg;

	// ****************************************
	// Register offsets and reset values
	// ****************************************
	localparam logic [7:0]  REG_CMD      = 8'h00;
	localparam logic [7:0]  REG_STATUS   = 8'h04;
	localparam logic [7:0]  REG_FE_BASE  = 8'h10;
	localparam logic [7:0]  REG_TIMER    = 8'h20;
	localparam logic [31:0] READ_ZERO    = 32'h0000_0000;
	localparam logic [7:0]  BYTE_RESET   = 8'h00;

	// ****************************************
	// Command codes
	// ****************************************
	localparam logic [7:0] OP_FE_CFG     = 8'h90;
	localparam logic [7:0] OP_FILTER     = 8'h30;
	localparam logic [7:0] OP_CNT_INIT   = 8'ha8;
	localparam logic [7:0] OP_STIMULUS   = 8'he0;
	localparam logic [7:0] OP_POWER_A    = 8'h82;
	localparam logic [7:0] OP_DRIVE_A    = 8'h86;
	localparam logic [7:0] OP_ENABLE_A   = 8'h8a;
	localparam logic [7:0] OP_DIGITAL    = 8'h8c;
	localparam logic [7:0] OP_IRQ_CLEAR  = 8'h70;
	localparam logic [7:0] OP_TIMER      = 8'hd0;
	localparam logic [7:0] OP_SINGLE     = 8'h40;
	localparam logic [7:0] STIM_HALF     = 8'h08;
	localparam logic [7:0] STIM_ALL      = 8'h0a;
	localparam logic [3:0] STROBES_HALF  = 4'h5;
	localparam logic [3:0] STROBES_ALL   = 4'hf;
	localparam logic [3:0] STROBES_NONE  = 4'h0;
	localparam logic [1:0] STIM_AMPL_ONE = 2'h1;
	localparam logic [1:0] STIM_AMPL_OFF = 2'h0;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [2:0] gainPrefix;
		logic [4:0] gain;
		logic [7:0] mainLevelThreshold;
		logic [7:0] coincidenceLevelThreshold;
		logic [1:0] filterMode;
	} tgpcd_fe_s;

	typedef struct packed {
		logic       power;
		logic       drive;
		logic       enable;
		logic       digital;
	} tgpcd_tel_s;

	typedef enum logic [2:0] {
		ST_OPCODE,
		ST_FE_GAIN,
		ST_FE_MAIN,
		ST_FE_COINC,
		ST_STIM_ARG,
		ST_TIMER_ARG
	} tgpcd_state_e;

endpackage

// ### verif/tgpcd_checker.sv
// Assertions on the ports of the command decoder.
`timescale 1ns/10ps
module tgpcd_checker (
	input wire logic                  clk,
	input wire logic                  reset_n,
	input wire logic                  hsel,
	input wire logic [31:0]           haddr,
	input wire logic [1:0]            htrans,
	input wire logic                  hwrite,
	input wire logic [31:0]           hwdata,
	input wire logic                  hready,
	input wire logic                  hreadyout,
	input wire logic                  hresp,
	input wire logic [3:0]            counterInit,
	input wire tgpcd_pkg::tgpcd_tel_s telescopeA,
	input wire logic [3:0]            stimulusStrobeEnable,
	input wire logic [1:0]            stimulusAmplitude,
	input wire logic                  irqClear
);
	logic       dp;
	wire  [7:0] b = hwdata[7:0];

	// Marks the data phase of a command write.
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n) dp <= 1'b0;
		else dp <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	bus_okay_a: assert property ($past(reset_n) |-> hreadyout && !hresp)
		else $error("bus not ready or not okay");
	irq_cause_a: assert property (
		irqClear |-> $past(dp) && $past(b) == 8'h70)
		else $error("irq clear without its opcode");
	irq_pulse_a: assert property (irqClear |=> !irqClear)
		else $error("irq clear longer than one cycle");
	cnt_init_a: assert property (counterInit != 4'h0 |-> $past(dp) &&
		$past(b[7:2]) == 6'h2a && counterInit == 4'h1 << $past(b[1:0]))
		else $error("counter init mismatch");
	power_on_a: assert property (
		$rose(telescopeA.power) |-> $past(dp) && $past(b) == 8'h82)
		else $error("power without its opcode");
	drive_on_a: assert property (
		$rose(telescopeA.drive) |-> $past(dp) && $past(b) == 8'h86)
		else $error("drive without its opcode");
	acq_on_a: assert property (
		$rose(telescopeA.enable) |-> $past(dp) && $past(b) == 8'h8a)
		else $error("enable without its opcode");
	digital_on_a: assert property (
		$rose(telescopeA.digital) |-> $past(dp) && $past(b) == 8'h8c)
		else $error("digital without its opcode");
	stim_level_a: assert property (stimulusAmplitude inside {2'h0, 2'h1} &&
		stimulusStrobeEnable inside {4'h0, 4'h5, 4'hf})
		else $error("stimulus pattern out of range");
	cover property (irqClear);
	cover property ($rose(telescopeA.digital));
	cover property (stimulusStrobeEnable == 4'hf);
endmodule

bind tgpcd_top tgpcd_checker chk (.clk, .reset_n, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hreadyout, .hresp, .counterInit, .telescopeA,
	.stimulusStrobeEnable, .stimulusAmplitude, .irqClear);

// ### verif/tgpcd_host.sv
// Host model that sends command bytes over the register bus.
`timescale 1ns/10ps
module tgpcd_host (
	input wire logic   clk,
	input wire logic   hready,
	input wire logic [31:0] hrdata,
	output logic       hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic       hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		{hsel, haddr, htrans, hwrite, hwdata} = '0;
		hsize = 3'h2;
	end
	task automatic wt();
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (hready !== 1'b1 && i < 50);
		if (hready !== 1'b1) tb_test_gen_and_power_on_command_decoder.fail();
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wt();
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		r = hrdata;
		hsel <= 1'b0;
		hwdata <= ~d;
		@(posedge clk);
	endtask
endmodule

// ### verif/tb_test_gen_and_power_on_command_decoder.sv
// Self-checking bench of the command decoder.
`timescale 1ns/10ps
module tb_test_gen_and_power_on_command_decoder;
	logic clk = 0, reset_n = 0, hsel, hwrite, hreadyout, hresp, irqClear;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans, stimulusAmplitude;
	logic [2:0] hsize;
	logic [3:0] counterInit, stimulusStrobeEnable, singleCounterSelect;
	logic [7:0] accumulationPeriod, g, m, c, a;
	tgpcd_pkg::tgpcd_fe_s [3:0] feConfig;
	tgpcd_pkg::tgpcd_tel_s telescopeA;
	logic [7:0] po[4] = '{8'h82, 8'h86, 8'h8a, 8'h8c};
	logic [3:0] tel[4] = '{4'h8, 4'hc, 4'he, 4'hf};
	int n_mismatch = 0, compares = 0;
	always #5 clk = ~clk;
	tgpcd_top dut (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .feConfig,
		.counterInit, .telescopeA, .stimulusStrobeEnable, .stimulusAmplitude,
		.accumulationPeriod, .singleCounterSelect, .irqClear);
	tgpcd_host host (.clk, .hready(hreadyout), .hrdata, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata);
	task automatic chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	function automatic logic [25:0] expFe(input logic [7:0] gb, mb, cb,
		input logic calib);
		return {gb, mb, cb, 1'b1, calib};
	endfunction
	function automatic logic [31:0] expStatus(input logic calib);
		return {8'h00, calib ? 8'h0a : 8'h08, 4'h1,
			calib ? 4'hf : 4'h5, 8'h0f};
	endfunction
	task automatic cmd(input logic [7:0] x);
		host.xfer(1'b1, 8'h00, {24'h0, x}, r);
	endtask
	task fail;
		n_mismatch++;
		conclude();
	endtask
	task conclude;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		void'($urandom(5));
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 4; i++) begin
			cmd(po[i]);
			chk(telescopeA, tel[i]);
		end
		cmd(8'h70);
		chk(irqClear, 1);
		$display("power-on test done");
		for (int t = 0; t < 2; t++) begin
			for (int n = 0; n < 4; n++) begin
				g = {2'b10, t[0], 5'($urandom)};
				m = n == 0 ? 8'h70 : 8'($urandom);
				c = 8'($urandom);
				cmd(8'h90 + 8'(n));
				cmd(g);
				cmd(m);
				chk(irqClear, 0);
				cmd(c);
				cmd({4'h3, 2'(n), 1'b1, t[0]});
				cmd(8'ha8 + 8'(n));
				chk(counterInit, 32'h1 << n);
				chk(feConfig[n], expFe(g, m, c, t[0]));
				host.xfer(1'b0, 8'h10 + 8'(n * 4), 32'h0, r);
				chk(r, {6'h00, expFe(g, m, c, t[0])});
			end
			a = 8'($urandom);
			cmd(8'hd0);
			cmd(a);
			cmd(t ? 8'h4a : 8'h48);
			chk(accumulationPeriod, a);
			host.xfer(1'b0, 8'h20, 32'h0, r);
			chk(r, {20'h0, t ? 4'ha : 4'h8, a});
			cmd(8'he0);
			cmd(t ? 8'h0a : 8'h08);
			chk(stimulusStrobeEnable, t ? 4'hf : 4'h5);
			cmd(8'h70);
			chk(irqClear, 1);
			host.xfer(1'b0, 8'h04, 32'h0, r);
			chk(r, expStatus(t[0]));
			$display("test generator pass %0d done", t);
		end
		host.xfer(1'b1, 8'h3c, 32'hffffffff, r);
		host.xfer(1'b0, 8'h3c, 32'h0, r);
		chk(r, 32'h0);
		$display("unmapped test done");
		conclude();
	end
endmodule
